//--- flash_cmd_params.svh
// Purpose: Constants for the flash command state machine
// Assumes: Command bytes arrive on the low eight data bits
// Notes:   Timing counts are in 10 ns clock cycles
`ifndef FLASH_CMD_PARAMS_SVH
`define FLASH_CMD_PARAMS_SVH
// ==========================================================
// Command codes
`define CMD_READ_ARRAY   8'hff
`define CMD_WORD_PROG_A  8'h10
`define CMD_WORD_PROG_B  8'h40
`define CMD_BUF_PROG     8'he8
`define CMD_ERASE_SETUP  8'h20
`define CMD_EFP_SETUP    8'h80
`define CMD_CONFIRM      8'hd0
`define CMD_SUSPEND      8'hb0
`define CMD_READ_STATUS  8'h70
`define CMD_CLEAR_STATUS 8'h50
`define CMD_READ_ID      8'h90
`define CMD_READ_QUERY   8'h98
`define CMD_LOCK_SETUP   8'h60
// Second bytes accepted after lock or configuration setup
`define CMD_LOCK_BLOCK   8'h01
`define CMD_LOCK_DOWN    8'h2f
`define CMD_CONFIG_SET   8'h03
// ==========================================================
// Status byte fields and reset value
`define STAT_READY_BIT   7
`define STAT_ESUSP_BIT   6
`define STAT_ERASE_BIT   5
`define STAT_PROG_BIT    4
`define STAT_RESET_VAL   8'h80
// ==========================================================
// Sizes
`define PART_COUNT       4
`define PART_IDX_W       2
`define WCOUNT_W         5
`endif

//--- flash_cmd_pkg.sv
// Purpose: Types for the flash command state machine
// Assumes: Used together with flash_cmd_params.svh
// Notes:   Nothing here is imported; users write the package prefix
package flash_cmd_pkg;
  // ==========================================================
  // Machine states
  typedef enum logic [4:0] {
    ST_READY, ST_LOCK_SETUP, ST_PROG_SETUP, ST_PROG_BUSY, ST_PROG_SUSP,
    ST_BUF_SETUP, ST_BUF_LOAD1, ST_BUF_LOAD2, ST_BUF_CONFIRM, ST_BUF_BUSY,
    ST_BUF_SUSP, ST_ERASE_SETUP, ST_ERASE_BUSY, ST_ERASE_SUSP,
    ST_EFP_SETUP, ST_ES_PROG_SETUP, ST_ES_PROG_BUSY, ST_ES_BUF_SETUP,
    ST_ES_BUF_LOAD1, ST_ES_BUF_LOAD2, ST_ES_BUF_CONFIRM, ST_ES_BUF_BUSY,
    ST_ES_LOCK_SETUP
  } cmd_state_t;
  // Per-partition read output mode
  typedef enum logic [1:0] {
    RM_ARRAY, RM_IDENT, RM_QUERY, RM_STATUS
  } read_mode_t;
  // One bus write from the host
  typedef struct packed {
    logic       valid;
    logic [1:0] part;
    logic [7:0] data;
  } host_write_t;
endpackage

//--- flash_command_state_machine.sv
// Purpose: Command decode and sequencing of a parallel NOR flash
// Assumes: One host write per i_wr.valid pulse; array op ends on i_op_done
// Notes:   Word count of a buffered load is the write after the setup byte
`timescale 1ns/100ps
`default_nettype none
`include "flash_cmd_params.svh"

// Behaviour
// - Only one partition programs or erases
// - Partition keeps read mode until changed
// - Next state ignores partition read mode
// - Buffered load: count, words, then confirm
// - Erase busy: only B0H suspends
// - Erase suspend decodes nested program, lock, resume
// - Ready decodes setups; others stay ready
// - Sequence error sets status bits 7,5,4
// - Reset clears status like clear-status
// - Bad suspended buffer confirm stays suspended
module flash_command_state_machine (
  input  wire logic                      i_clk,
  input  wire logic                      i_rst_b,
  input  wire flash_cmd_pkg::host_write_t i_wr,
  input  wire logic                      i_op_done,
  output logic [7:0]                     o_status,
  output flash_cmd_pkg::cmd_state_t      o_state,
  output logic                           o_op_active,
  output logic [`PART_IDX_W-1:0]         o_op_part,
  output logic [2*`PART_COUNT-1:0]       o_read_modes
);
  // ==========================================================
  // Decode of the incoming byte
  wire       wr_en   = i_wr.valid;
  wire [7:0] cmd     = i_wr.data;
  wire is_prog  = (cmd == `CMD_WORD_PROG_A) || (cmd == `CMD_WORD_PROG_B);
  wire is_conf  = (cmd == `CMD_CONFIRM);
  wire is_susp  = (cmd == `CMD_SUSPEND);
  wire is_clear = (cmd == `CMD_CLEAR_STATUS);
  wire is_lock_ok = is_conf || (cmd == `CMD_LOCK_BLOCK) || (cmd == `CMD_LOCK_DOWN) ||
                    (cmd == `CMD_CONFIG_SET);

  flash_cmd_pkg::cmd_state_t state;
  flash_cmd_pkg::cmd_state_t next_state;
  logic [`WCOUNT_W-1:0]      words_left;
  logic [`WCOUNT_W-1:0]      next_words_left;
  logic                      seq_err;
  logic                      starts_op;

  // ==========================================================
  // Next state; read modes never enter here, so output mode cannot steer it
  always_comb begin
    next_state      = state;
    next_words_left = words_left;
    seq_err         = 1'b0;
    starts_op       = 1'b0;
    if (wr_en) begin
      unique case (state)
        flash_cmd_pkg::ST_READY: begin
          if (is_prog) next_state = flash_cmd_pkg::ST_PROG_SETUP;
          else if (cmd == `CMD_BUF_PROG) next_state = flash_cmd_pkg::ST_BUF_SETUP;
          else if (cmd == `CMD_ERASE_SETUP) next_state = flash_cmd_pkg::ST_ERASE_SETUP;
          else if (cmd == `CMD_EFP_SETUP) next_state = flash_cmd_pkg::ST_EFP_SETUP;
          else if (cmd == `CMD_LOCK_SETUP) next_state = flash_cmd_pkg::ST_LOCK_SETUP;
        end
        flash_cmd_pkg::ST_LOCK_SETUP: begin
          next_state = flash_cmd_pkg::ST_READY;
          seq_err    = !is_lock_ok;
        end
        flash_cmd_pkg::ST_EFP_SETUP: begin
          next_state = flash_cmd_pkg::ST_READY;
          seq_err    = !is_conf;
        end
        flash_cmd_pkg::ST_PROG_SETUP: begin
          next_state = flash_cmd_pkg::ST_PROG_BUSY;
          starts_op  = 1'b1;
        end
        flash_cmd_pkg::ST_PROG_BUSY:
          if (is_susp) next_state = flash_cmd_pkg::ST_PROG_SUSP;
        flash_cmd_pkg::ST_PROG_SUSP:
          if (is_conf) next_state = flash_cmd_pkg::ST_PROG_BUSY;
        // Count write tells how many words follow the first one
        flash_cmd_pkg::ST_BUF_SETUP, flash_cmd_pkg::ST_ES_BUF_SETUP: begin
          next_words_left = cmd[`WCOUNT_W-1:0];
          next_state = (state == flash_cmd_pkg::ST_BUF_SETUP) ?
                       flash_cmd_pkg::ST_BUF_LOAD1 : flash_cmd_pkg::ST_ES_BUF_LOAD1;
        end
        flash_cmd_pkg::ST_BUF_LOAD1, flash_cmd_pkg::ST_BUF_LOAD2: begin
          next_words_left = words_left - `WCOUNT_W'(1);
          next_state = (words_left == '0) ? flash_cmd_pkg::ST_BUF_CONFIRM :
                                            flash_cmd_pkg::ST_BUF_LOAD2;
        end
        flash_cmd_pkg::ST_ES_BUF_LOAD1, flash_cmd_pkg::ST_ES_BUF_LOAD2: begin
          next_words_left = words_left - `WCOUNT_W'(1);
          next_state = (words_left == '0) ? flash_cmd_pkg::ST_ES_BUF_CONFIRM :
                                            flash_cmd_pkg::ST_ES_BUF_LOAD2;
        end
        flash_cmd_pkg::ST_BUF_CONFIRM: begin
          starts_op  = is_conf;
          seq_err    = !is_conf;
          next_state = is_conf ? flash_cmd_pkg::ST_BUF_BUSY : flash_cmd_pkg::ST_READY;
        end
        flash_cmd_pkg::ST_BUF_BUSY:
          if (is_susp) next_state = flash_cmd_pkg::ST_BUF_SUSP;
        flash_cmd_pkg::ST_BUF_SUSP:
          if (is_conf) next_state = flash_cmd_pkg::ST_BUF_BUSY;
        flash_cmd_pkg::ST_ERASE_SETUP: begin
          starts_op  = is_conf;
          seq_err    = !is_conf;
          next_state = is_conf ? flash_cmd_pkg::ST_ERASE_BUSY : flash_cmd_pkg::ST_READY;
        end
        flash_cmd_pkg::ST_ERASE_BUSY:
          if (is_susp) next_state = flash_cmd_pkg::ST_ERASE_SUSP;
        flash_cmd_pkg::ST_ERASE_SUSP: begin
          if (is_prog) next_state = flash_cmd_pkg::ST_ES_PROG_SETUP;
          else if (cmd == `CMD_BUF_PROG) next_state = flash_cmd_pkg::ST_ES_BUF_SETUP;
          else if (cmd == `CMD_LOCK_SETUP) next_state = flash_cmd_pkg::ST_ES_LOCK_SETUP;
          else if (is_conf) next_state = flash_cmd_pkg::ST_ERASE_BUSY;
        end
        flash_cmd_pkg::ST_ES_PROG_SETUP: next_state = flash_cmd_pkg::ST_ES_PROG_BUSY;
        flash_cmd_pkg::ST_ES_BUF_CONFIRM: begin
          seq_err    = !is_conf;
          next_state = is_conf ? flash_cmd_pkg::ST_ES_BUF_BUSY : flash_cmd_pkg::ST_ERASE_SUSP;
        end
        flash_cmd_pkg::ST_ES_LOCK_SETUP: begin
          next_state = flash_cmd_pkg::ST_ERASE_SUSP;
          seq_err    = !is_lock_ok;
        end
        default: ;
      endcase
    end
    // Completion of the array operation returns to the parked state
    if (i_op_done) begin
      unique case (state)
        flash_cmd_pkg::ST_PROG_BUSY, flash_cmd_pkg::ST_BUF_BUSY,
        flash_cmd_pkg::ST_ERASE_BUSY: next_state = flash_cmd_pkg::ST_READY;
        flash_cmd_pkg::ST_ES_PROG_BUSY,
        flash_cmd_pkg::ST_ES_BUF_BUSY: next_state = flash_cmd_pkg::ST_ERASE_SUSP;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Busy decode; a single op register means one partition at a time
  wire op_busy = (state == flash_cmd_pkg::ST_PROG_BUSY) || (state == flash_cmd_pkg::ST_BUF_BUSY) ||
                 (state == flash_cmd_pkg::ST_ERASE_BUSY) ||
                 (state == flash_cmd_pkg::ST_ES_PROG_BUSY) ||
                 (state == flash_cmd_pkg::ST_ES_BUF_BUSY);
  wire next_busy = (next_state == flash_cmd_pkg::ST_PROG_BUSY) ||
                   (next_state == flash_cmd_pkg::ST_BUF_BUSY) ||
                   (next_state == flash_cmd_pkg::ST_ERASE_BUSY) ||
                   (next_state == flash_cmd_pkg::ST_ES_PROG_BUSY) ||
                   (next_state == flash_cmd_pkg::ST_ES_BUF_BUSY);
  wire in_esusp = (next_state == flash_cmd_pkg::ST_ERASE_SUSP);

  // State, owner partition and word counter
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      state       <= flash_cmd_pkg::ST_READY;
      words_left  <= '0;
      o_op_part   <= '0;
      o_op_active <= 1'b0;
    end else begin
      state       <= next_state;
      words_left  <= next_words_left;
      o_op_active <= next_busy;
      if (starts_op) o_op_part <= i_wr.part;
    end
  end
  assign o_state = state;

  // ==========================================================
  // Status byte: error bits sticky until clear or reset
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_status <= `STAT_RESET_VAL;
    end else begin
      o_status[`STAT_READY_BIT] <= !next_busy || seq_err;
      o_status[`STAT_ESUSP_BIT] <= in_esusp;
      if (seq_err) begin
        o_status[`STAT_ERASE_BIT] <= 1'b1;
        o_status[`STAT_PROG_BIT]  <= 1'b1;
      end else if (wr_en && is_clear && !op_busy) begin
        o_status[5:0] <= '0; // Same effect as reset
      end
    end
  end

  // ==========================================================
  // Per-partition read mode, held until a mode command hits it
  wire [2*`PART_COUNT-1:0] next_read_modes;
  genvar gp;
  generate
    for (gp = 0; gp < `PART_COUNT; gp++) begin : g_part
      wire       hit  = wr_en && (i_wr.part == `PART_IDX_W'(gp));
      wire [1:0] held = o_read_modes[2*gp +: 2];
      assign next_read_modes[2*gp +: 2] =
        !hit                      ? held :
        (cmd == `CMD_READ_ARRAY)  ? 2'(flash_cmd_pkg::RM_ARRAY) :
        (cmd == `CMD_READ_ID)     ? 2'(flash_cmd_pkg::RM_IDENT) :
        (cmd == `CMD_READ_QUERY)  ? 2'(flash_cmd_pkg::RM_QUERY) :
        (cmd == `CMD_READ_STATUS) ? 2'(flash_cmd_pkg::RM_STATUS) : held;
    end
  endgenerate

  // One register for all partitions, so the output has a single driver
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_read_modes <= {`PART_COUNT{2'(flash_cmd_pkg::RM_ARRAY)}};
    end else begin
      o_read_modes <= next_read_modes;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  sequence s_erase_busy_write;
    state == flash_cmd_pkg::ST_ERASE_BUSY && wr_en && !i_op_done;
  endsequence

  a_erase_susp_entry: assert property ((s_erase_busy_write and is_susp)
    |=> state == flash_cmd_pkg::ST_ERASE_SUSP) else $error("erase suspend missed");
  a_erase_keeps_busy: assert property ((s_erase_busy_write and !is_susp)
    |=> state == flash_cmd_pkg::ST_ERASE_BUSY) else $error("erase left busy");
  a_erase_setup_err: assert property (state == flash_cmd_pkg::ST_ERASE_SETUP && wr_en
    && !is_conf |=> state == flash_cmd_pkg::ST_READY && o_status[5:4] == 2'b11)
    else $error("erase setup error");
  a_seq_err_bits: assert property (seq_err |=> o_status[7] && o_status[5] && o_status[4])
    else $error("error bits not set");
  a_es_buf_bad: assert property (state == flash_cmd_pkg::ST_ES_BUF_CONFIRM && wr_en
    && !is_conf |=> state == flash_cmd_pkg::ST_ERASE_SUSP && o_status[6])
    else $error("suspend lost on bad confirm");
  a_ready_prog: assert property (state == flash_cmd_pkg::ST_READY && wr_en && is_prog
    |=> state == flash_cmd_pkg::ST_PROG_SETUP) else $error("program setup missed");
  a_ready_stays: assert property (state == flash_cmd_pkg::ST_READY && wr_en && is_susp
    |=> state == flash_cmd_pkg::ST_READY) else $error("ready left on suspend");
  a_es_resume: assert property (state == flash_cmd_pkg::ST_ERASE_SUSP && wr_en && is_conf
    |=> state == flash_cmd_pkg::ST_ERASE_BUSY) else $error("resume missed");
  a_buf_load_seq: assert property (state == flash_cmd_pkg::ST_BUF_SETUP && wr_en
    |=> state == flash_cmd_pkg::ST_BUF_LOAD1) else $error("load step 1 missed");
  a_mode_hold: assert property (!wr_en |=> $stable(o_read_modes))
    else $error("read mode changed without write");
  a_one_owner: assert property (o_op_active && !starts_op |=> $stable(o_op_part))
    else $error("owner partition changed");
endmodule // flash_command_state_machine
`default_nettype wire

//--- flash_host_model.sv
// Purpose: Host side model that writes command bytes to the flash
// Assumes: One write per call, launched 1 ns after a rising edge
// Notes:   Valid drops after the taking edge, so writes are two cycles apart
`timescale 1ns/100ps
`default_nettype none
module flash_host_model (
  input  wire logic                       i_clk,
  output var  flash_cmd_pkg::host_write_t o_wr
);
  initial o_wr = '0;
  // One write, held until the edge that takes it
  task automatic write(input logic [1:0] part, input logic [7:0] data);
    @(posedge i_clk);
    #1;
    o_wr = {1'b1, part, data};
    @(posedge i_clk);
    #1;
    o_wr = {1'b0, ~part, ~data}; // Released bus shows inverted data
  endtask
  // Buffered load: count write, then exactly count plus one words
  task automatic buf_load(input logic [1:0] part, input logic [4:0] n);
    write(part, {3'h0, n});
    for (int k = 0; k <= n; k++) write(part, 8'h30 + k[7:0]);
  endtask
endmodule // flash_host_model
`default_nettype wire

//--- tb.sv
// Purpose: Self-checking bench of the flash command state machine
// Assumes: Host model drives writes; bench drives reset and op done
// Notes:   Each scenario starts from a fresh reset
`timescale 1ns/100ps
`default_nettype none
`include "flash_cmd_params.svh"
module tb;
  logic                       clk;
  logic                       rst_b;
  logic                       done;
  flash_cmd_pkg::host_write_t wr;
  logic [7:0]                 status;
  flash_cmd_pkg::cmd_state_t  state;
  logic                       op_active;
  logic [1:0]                 op_part;
  logic [7:0]                 modes;
  int                         fails;
  int                         checks;
  int                         cycles = 0;
  flash_host_model i_flash_host_model (.i_clk(clk), .o_wr(wr));
  flash_command_state_machine i_flash_command_state_machine (
    .i_clk(clk), .i_rst_b(rst_b), .i_wr(wr), .i_op_done(done), .o_status(status),
    .o_state(state), .o_op_active(op_active), .o_op_part(op_part), .o_read_modes(modes));
  // ==========================================================
  // Clock, timeout and helpers
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Bound sized well above the roughly 170 cycles the scenarios need
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails = fails + 1;
      give_verdict();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_cmd(input logic [1:0] p, input logic [7:0] d);
    i_flash_host_model.write(p, d);
  endtask
  task automatic st(input flash_cmd_pkg::cmd_state_t e);
    chk({3'h0, state}, {3'h0, e});
  endtask
  task automatic reset_dut();
    @(posedge clk);
    #1;
    rst_b = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    rst_b = 1'b1;
  endtask
  task automatic op_done();
    @(posedge clk);
    #1;
    done = 1'b1;
    @(posedge clk);
    #1;
    done = 1'b0;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_ready_decode();
    logic [7:0] c [11] = '{8'hff, 8'hb0, 8'h70, 8'h50, 8'h90, 8'h98,
                           8'h10, 8'he8, 8'h20, 8'h80, 8'h60};
    flash_cmd_pkg::cmd_state_t e [11] = '{flash_cmd_pkg::ST_READY, flash_cmd_pkg::ST_READY,
      flash_cmd_pkg::ST_READY, flash_cmd_pkg::ST_READY, flash_cmd_pkg::ST_READY,
      flash_cmd_pkg::ST_READY, flash_cmd_pkg::ST_PROG_SETUP, flash_cmd_pkg::ST_BUF_SETUP,
      flash_cmd_pkg::ST_ERASE_SETUP, flash_cmd_pkg::ST_EFP_SETUP,
      flash_cmd_pkg::ST_LOCK_SETUP};
    for (int k = 0; k < 11; k++) begin
      reset_dut();
      chk(status, `STAT_RESET_VAL);
      wr_cmd(2'h1, c[k]);
      st(e[k]);
    end
  endtask
  task automatic t_erase_setup_error();
    reset_dut();
    wr_cmd(2'h0, `CMD_ERASE_SETUP);
    wr_cmd(2'h0, `CMD_READ_STATUS);
    st(flash_cmd_pkg::ST_READY);
    chk(status & 8'hb0, 8'hb0);
    wr_cmd(2'h0, `CMD_CLEAR_STATUS);
    chk(status, `STAT_RESET_VAL);
  endtask
  task automatic t_buffered();
    reset_dut();
    wr_cmd(2'h2, `CMD_BUF_PROG);
    wr_cmd(2'h2, 8'h02);
    st(flash_cmd_pkg::ST_BUF_LOAD1);
    wr_cmd(2'h2, 8'h11);
    wr_cmd(2'h2, 8'h12);
    st(flash_cmd_pkg::ST_BUF_LOAD2);
    wr_cmd(2'h2, 8'h13);
    st(flash_cmd_pkg::ST_BUF_CONFIRM);
    wr_cmd(2'h2, `CMD_CONFIRM);
    st(flash_cmd_pkg::ST_BUF_BUSY);
    chk({5'h0, op_active, op_part}, 8'h06);
    op_done();
    st(flash_cmd_pkg::ST_READY);
  endtask
  task automatic t_erase_suspend();
    reset_dut();
    wr_cmd(2'h2, `CMD_ERASE_SETUP);
    wr_cmd(2'h2, `CMD_CONFIRM);
    chk({3'h0, status[7], op_active, 1'b0, op_part}, 8'h0a);
    wr_cmd(2'h3, `CMD_BUF_PROG);
    wr_cmd(2'h1, `CMD_LOCK_SETUP);
    st(flash_cmd_pkg::ST_ERASE_BUSY);
    chk({6'h0, op_part}, 8'h02);
    wr_cmd(2'h2, `CMD_SUSPEND);
    st(flash_cmd_pkg::ST_ERASE_SUSP);
    chk(status & 8'h40, 8'h40);
    wr_cmd(2'h2, `CMD_READ_STATUS);
    st(flash_cmd_pkg::ST_ERASE_SUSP);
    wr_cmd(2'h1, `CMD_WORD_PROG_B);
    st(flash_cmd_pkg::ST_ES_PROG_SETUP);
    wr_cmd(2'h1, 8'h5a);
    st(flash_cmd_pkg::ST_ES_PROG_BUSY);
    op_done();
    wr_cmd(2'h1, `CMD_LOCK_SETUP);
    st(flash_cmd_pkg::ST_ES_LOCK_SETUP);
    wr_cmd(2'h1, `CMD_CONFIRM);
    wr_cmd(2'h1, `CMD_BUF_PROG);
    st(flash_cmd_pkg::ST_ES_BUF_SETUP);
    i_flash_host_model.buf_load(2'h1, 5'h00);
    wr_cmd(2'h1, `CMD_READ_ARRAY);
    st(flash_cmd_pkg::ST_ERASE_SUSP);
    chk(status & 8'hb0, 8'hb0);
    wr_cmd(2'h1, `CMD_CONFIRM);
    st(flash_cmd_pkg::ST_ERASE_BUSY);
    op_done();
    st(flash_cmd_pkg::ST_READY);
  endtask
  task automatic t_read_modes();
    reset_dut();
    wr_cmd(2'h1, `CMD_READ_ID);
    wr_cmd(2'h2, `CMD_READ_QUERY);
    wr_cmd(2'h3, `CMD_READ_STATUS);
    chk(modes, 8'he4);
    wr_cmd(2'h1, `CMD_READ_ARRAY);
    chk(modes, 8'he0);
    wr_cmd(2'h2, `CMD_BUF_PROG);
    st(flash_cmd_pkg::ST_BUF_SETUP);
  endtask
  // ==========================================================
  // Main sequence and verdict
  task automatic give_verdict();
    if (fails == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    fails = 0;
    checks = 0;
    rst_b = 1'b0;
    done = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    rst_b = 1'b1;
    chk(status, `STAT_RESET_VAL);
    st(flash_cmd_pkg::ST_READY);
    t_ready_decode();
    t_erase_setup_error();
    t_buffered();
    t_erase_suspend();
    t_read_modes();
    give_verdict();
  end
endmodule // tb
`default_nettype wire
